// ---- ums_pkg.sv ----
/*
 * Scheduler constants: register map, fields, timing table, gaps.
 * Assumes one core clock; times are typical, in us.
 */
`default_nettype none

package ums_pkg;

   // core clock
   localparam int unsigned UMS_CLK_PERIOD_NS = 5;
   localparam int unsigned UMS_CYC_PER_US    = 1000 / UMS_CLK_PERIOD_NS;

   // register byte offsets
   localparam logic [7:0] UMS_REG_CONFIG   = 8'h00;
   localparam logic [7:0] UMS_REG_STATUS   = 8'h04;
   localparam logic [7:0] UMS_REG_RESULT   = 8'h08;
   localparam logic [7:0] UMS_REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] UMS_REG_IRQ_MASK = 8'h10;
   localparam logic [7:0] UMS_REG_CONTROL  = 8'h14;

   // config fields
   localparam int unsigned UMS_CFG_CLK4_BIT = 0;
   localparam int unsigned UMS_CFG_LONG_BIT = 1;
   localparam int unsigned UMS_CFG_I2C_BIT  = 2;
   localparam int unsigned UMS_CFG_RATE_LSB = 6;
   localparam int unsigned UMS_CFG_RATE_MSB = 7;
   localparam logic [7:0]  UMS_CFG_RESET    = 8'h04;

   // control fields (write-only pulses)
   localparam int unsigned UMS_CTL_EXIT_CMD_BIT = 0;

   // status register fields
   localparam int unsigned UMS_ST_PDOWN_BIT = 0;
   localparam int unsigned UMS_ST_CMD_BIT   = 1;
   localparam int unsigned UMS_ST_VALID_BIT = 2;
   localparam int unsigned UMS_ST_STALE_BIT = 3;
   localparam int unsigned UMS_ST_DIAG_BIT  = 4;
   localparam int unsigned UMS_ST_NEXTAZ_BIT = 5;
   localparam int unsigned UMS_ST_GAP_LSB   = 8;

   // interrupt status bits
   localparam int unsigned UMS_IRQ_W       = 3;
   localparam int unsigned UMS_IRQ_RESULT  = 0;
   localparam int unsigned UMS_IRQ_SPECIAL = 1;
   localparam int unsigned UMS_IRQ_FETCH   = 2;

   // packet status codes (two msbs)
   localparam logic [1:0] UMS_PKT_GOOD  = 2'h0;
   localparam logic [1:0] UMS_PKT_CMD   = 2'h1;
   localparam logic [1:0] UMS_PKT_STALE = 2'h2;
   localparam logic [1:0] UMS_PKT_DIAG  = 2'h3;

   localparam logic [1:0] UMS_RATE_FASTEST = 2'h0;
   localparam int unsigned UMS_DATA_W      = 14;

   // command window lengths
   localparam int unsigned UMS_WIN_LOCKED_US = 1500;
   localparam int unsigned UMS_WIN_EXTRA_US  = 4500;

   // update periods, normal and long integration, 1 MHz and 4 MHz core
   localparam int unsigned UMS_PER_N1_US [4] = '{1600, 5000, 25000, 125000};
   localparam int unsigned UMS_PER_N4_US [4] = '{500, 1500, 6500, 32000};
   localparam int unsigned UMS_PER_L1_US [4] = '{5000, 8500, 30000, 130000};
   localparam int unsigned UMS_PER_L4_US [4] = '{1500, 2500, 7500, 33000};

   // ordinary cycles between special measurements
   localparam logic [7:0] UMS_GAP [4] = '{8'hFF, 8'h7F, 8'h1F, 8'h0F};

   // worst case factor in percent of typical
   localparam int unsigned UMS_WORST_PCT = 115;

   // conversion kinds
   typedef enum logic [1:0] {
      UMS_CONV_BRIDGE,
      UMS_CONV_TEMP,
      UMS_CONV_ZERO
   } ums_conv_e;

   typedef enum {
      UMS_S_BOOT,
      UMS_S_WINDOW,
      UMS_S_CMD,
      UMS_S_START,
      UMS_S_CONV,
      UMS_S_CALC,
      UMS_S_SLEEP
   } ums_state_e;

endpackage

`default_nettype wire

// ---- ums_scheduler.sv ----
/*
 * Update-mode scheduler with AXI4-Lite register slave.
 * Assumes converter, correction and serial front end run on clock_in
 * with one-cycle done and fetch pulses; no synchronisers.
 */
// Implementation choices: the AXI4-Lite slave port and the register offsets.
// Behaviour
// R1: update mode loops measurement and correction, refreshing the output register
// R2: rate 00 runs cycles back to back with no power-down
// R3: other rates power down right after the result is written
// R4: power-down length comes from rate bits [7:6] and the core clock choice
// R5: after power-down: wake, convert bridge, correct, store result, sleep again
// R6: special measurement every 255, 127, 31 or 15 cycles by rate
// R7: normal periods 1.6/5/25/125 ms at 1 MHz, 0.5/1.5/6.5/32 ms at 4 MHz
// R8: long periods 5/8.5/30/130 ms at 1 MHz, 1.5/2.5/7.5/33 ms at 4 MHz
// R9: data is valid only after measurement and correction; host fetches it
// R10: after the host reads valid data, status reads stale until a new result
// R11: host polls no faster than the update period plus 20 percent
// R12: in I2C mode the ready pin rises when fresh valid data is available
// R13: a special measurement is followed at once by a bridge measurement
// R14: a cycle with a special measurement is one conversion time longer
// R15: unlocked memory stretches the command window by 4.5 ms to 6 ms
// R16: all durations are typical oscillator values; worst case is 1.15 times
// R17: packet msbs: 00 good, 01 command mode, 10 stale, 11 diagnostic
// R18: locked memory: listen 1.5 ms for command-mode entry, then start
// R19: gap counter reloads from rate and alternates temperature and zeroing
`default_nettype none

module ums_scheduler
   import ums_pkg::*;
#(
   parameter int unsigned CYCLES_PER_US = UMS_CYC_PER_US,
   parameter int unsigned CONV_TIME_US  = 100
) (
   input  wire logic                  clock_in,
   input  wire logic                  rst_b_in,
   input  wire logic                  clk_en_in,
   // axi4-lite slave
   input  wire logic [7:0]            s_axi_awaddr_in,
   input  wire logic                  s_axi_awvalid_in,
   output logic                       s_axi_awready_out,
   input  wire logic [31:0]           s_axi_wdata_in,
   input  wire logic [3:0]            s_axi_wstrb_in,
   input  wire logic                  s_axi_wvalid_in,
   output logic                       s_axi_wready_out,
   output logic [1:0]                 s_axi_bresp_out,
   output logic                       s_axi_bvalid_out,
   input  wire logic                  s_axi_bready_in,
   input  wire logic [7:0]            s_axi_araddr_in,
   input  wire logic                  s_axi_arvalid_in,
   output logic                       s_axi_arready_out,
   output logic [31:0]                s_axi_rdata_out,
   output logic [1:0]                 s_axi_rresp_out,
   output logic                       s_axi_rvalid_out,
   input  wire logic                  s_axi_rready_in,
   // configuration memory and command-mode entry
   input  wire logic                  mem_unlocked_in,
   input  wire logic                  enter_command_mode_request_in,
   // converter on the bridge_input_pair and sensors
   output logic                       conv_start_out,
   output logic [1:0]                 conv_kind_out,
   input  wire logic                  conv_done_in,
   input  wire logic                  diag_fault_in,
   // correction engine
   output logic                       calc_start_out,
   input  wire logic                  calc_done_in,
   input  wire logic [UMS_DATA_W-1:0] calc_result_in,
   // serial front end
   input  wire logic                  result_fetch_command_in,
   output logic [15:0]                packet_out,
   output logic                       ready_pin_out,
   output logic                       power_down_out,
   output logic                       irq_out
);

   localparam logic [31:0] CONV_CYC = 32'(CONV_TIME_US * CYCLES_PER_US);
   localparam logic [31:0] WIN_LOCK_CYC = 32'(UMS_WIN_LOCKED_US * CYCLES_PER_US);
   localparam logic [31:0] WIN_OPEN_CYC =
      32'((UMS_WIN_LOCKED_US + UMS_WIN_EXTRA_US) * CYCLES_PER_US);

   // typical period in core cycles; worst case is the oscillator's problem [R16]
   function automatic logic [31:0] period_cyc(input logic [1:0] r,
                                              input logic       f4,
                                              input logic       li);
      int unsigned us;
      if (li) begin
         us = f4 ? UMS_PER_L4_US[r] : UMS_PER_L1_US[r]; // [R8]
      end else begin
         us = f4 ? UMS_PER_N4_US[r] : UMS_PER_N1_US[r]; // [R7]
      end
      return 32'(us * CYCLES_PER_US);
   endfunction

   ums_state_e              state_ff;
   logic [7:0]              cfg_ff;
   logic [UMS_IRQ_W-1:0]    irq_stat_ff;
   logic [UMS_IRQ_W-1:0]    irq_mask_ff;
   logic [31:0]             timer_ff;
   logic [7:0]              gap_ff;
   logic                    need_temp_ff;
   logic                    need_zero_ff;
   logic                    next_zero_ff;
   logic                    first_ff;
   logic [UMS_DATA_W-1:0]   result_ff;
   logic                    valid_ff;
   logic                    stale_ff;
   logic                    diag_ff;
   logic                    exit_cmd_ff;
   logic                    result_wr;
   logic                    special_done;
   logic [1:0]              rate;
   logic [1:0]              pkt_status;

   // axi state
   logic                    aw_held_ff;
   logic                    w_held_ff;
   logic [7:0]              awaddr_ff;
   logic [31:0]             wdata_ff;
   logic [3:0]              wstrb_ff;
   logic                    wr_fire;
   logic                    wr_ok;

   assign rate = cfg_ff[UMS_CFG_RATE_MSB:UMS_CFG_RATE_LSB]; // [R4]
   assign result_wr = (state_ff == UMS_S_CALC) && calc_done_in;
   assign special_done = (state_ff == UMS_S_CONV) && conv_done_in
                         && (conv_kind_out != UMS_CONV_BRIDGE);
   assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid_out;
   assign wr_ok = (awaddr_ff == UMS_REG_CONFIG) || (awaddr_ff == UMS_REG_IRQ_STAT)
                  || (awaddr_ff == UMS_REG_IRQ_MASK) || (awaddr_ff == UMS_REG_CONTROL)
                  || (awaddr_ff == UMS_REG_STATUS) || (awaddr_ff == UMS_REG_RESULT);

   // packet status: diagnostic, then command mode, then freshness [R17]
   always_comb begin
      if (diag_ff) begin
         pkt_status = UMS_PKT_DIAG;
      end else if (state_ff == UMS_S_CMD) begin
         pkt_status = UMS_PKT_CMD;
      end else if (valid_ff && !stale_ff) begin
         pkt_status = UMS_PKT_GOOD;
      end else begin
         pkt_status = UMS_PKT_STALE; // also before the first result exists
      end
   end

   // measurement sequencer
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_ff       <= UMS_S_BOOT;
         timer_ff       <= 32'h0000_0000;
         gap_ff         <= 8'h00;
         need_temp_ff   <= 1'b0;
         need_zero_ff   <= 1'b0;
         next_zero_ff   <= 1'b0;
         first_ff       <= 1'b0;
         conv_start_out <= 1'b0;
         conv_kind_out  <= UMS_CONV_BRIDGE;
         calc_start_out <= 1'b0;
         power_down_out <= 1'b0;
      end else if (clk_en_in) begin
         conv_start_out <= 1'b0;
         calc_start_out <= 1'b0;
         if (timer_ff != 32'h0000_0000) begin
            timer_ff <= timer_ff - 32'h0000_0001;
         end
         unique case (state_ff)
            UMS_S_BOOT: begin
               // strap level read once after reset
               timer_ff <= mem_unlocked_in ? WIN_OPEN_CYC : WIN_LOCK_CYC; // [R15] [R18]
               state_ff <= UMS_S_WINDOW;
            end
            UMS_S_WINDOW: begin
               if (enter_command_mode_request_in) begin
                  state_ff <= UMS_S_CMD; // [R18]
               end else if (timer_ff == 32'h0000_0000) begin
                  need_temp_ff <= 1'b1;
                  need_zero_ff <= 1'b1;
                  gap_ff       <= UMS_GAP[rate];
                  first_ff     <= 1'b1;
                  state_ff     <= UMS_S_START; // [R18]
               end
            end
            UMS_S_CMD: begin
               if (exit_cmd_ff) begin
                  need_temp_ff <= 1'b1;
                  need_zero_ff <= 1'b1;
                  gap_ff       <= UMS_GAP[rate];
                  first_ff     <= 1'b1;
                  state_ff     <= UMS_S_START;
               end
            end
            UMS_S_START: begin
               power_down_out <= 1'b0;
               conv_start_out <= 1'b1;
               if (need_temp_ff) begin
                  conv_kind_out <= UMS_CONV_TEMP;
               end else if (need_zero_ff) begin
                  conv_kind_out <= UMS_CONV_ZERO;
               end else begin
                  conv_kind_out <= UMS_CONV_BRIDGE;
               end
               if (first_ff) begin
                  // period counts start to start; each special adds a conversion [R14]
                  timer_ff <= period_cyc(rate, cfg_ff[UMS_CFG_CLK4_BIT],
                                         cfg_ff[UMS_CFG_LONG_BIT])
                              + (need_temp_ff ? CONV_CYC : 32'h0000_0000)
                              + (need_zero_ff ? CONV_CYC : 32'h0000_0000);
                  first_ff <= 1'b0;
               end
               state_ff <= UMS_S_CONV;
            end
            UMS_S_CONV: begin
               if (conv_done_in) begin
                  if (conv_kind_out == UMS_CONV_BRIDGE) begin
                     calc_start_out <= 1'b1; // [R5]
                     state_ff       <= UMS_S_CALC;
                  end else begin
                     if (conv_kind_out == UMS_CONV_TEMP) begin
                        need_temp_ff <= 1'b0;
                     end else begin
                        need_zero_ff <= 1'b0;
                     end
                     state_ff <= UMS_S_START; // zeroing follows if still pending, else bridge, in same cycle [R13]
                  end
               end
            end
            UMS_S_CALC: begin
               if (calc_done_in) begin
                  // gap counter: reload and pick the other special kind [R6] [R19]
                  if (gap_ff == 8'h00) begin
                     gap_ff       <= UMS_GAP[rate];
                     next_zero_ff <= !next_zero_ff;
                     if (next_zero_ff) begin
                        need_zero_ff <= 1'b1;
                     end else begin
                        need_temp_ff <= 1'b1;
                     end
                  end else begin
                     gap_ff <= gap_ff - 8'h01;
                  end
                  first_ff <= 1'b1;
                  if (rate == UMS_RATE_FASTEST) begin
                     state_ff <= UMS_S_START; // back to back [R2] [R1]
                  end else begin
                     power_down_out <= 1'b1; // [R3]
                     state_ff       <= UMS_S_SLEEP;
                  end
               end
            end
            UMS_S_SLEEP: begin
               // leave at 2 so the next start lands exactly one period on
               if (timer_ff <= 32'h0000_0002) begin
                  state_ff <= UMS_S_START; // wake when period ends [R4] [R5]
               end
            end
         endcase
      end
   end

   // output register, freshness and diagnostics
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         result_ff <= '0;
         valid_ff  <= 1'b0;
         stale_ff  <= 1'b0;
         diag_ff   <= 1'b0;
      end else if (clk_en_in) begin
         if (result_wr) begin
            result_ff <= calc_result_in; // [R1]
            valid_ff  <= 1'b1;           // only after correction [R9]
            stale_ff  <= 1'b0;           // new result beats a same-cycle fetch
            if (diag_fault_in) begin
               diag_ff <= 1'b1; // held until reset
            end
         end else if (result_fetch_command_in && valid_ff) begin
            stale_ff <= 1'b1; // [R10]
         end
      end
   end

   // registered packet and ready pin, one cycle late
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         packet_out    <= {UMS_PKT_STALE, 14'h0000};
         ready_pin_out <= 1'b0;
      end else if (clk_en_in) begin
         packet_out    <= {pkt_status, result_ff}; // [R17] [R9]
         ready_pin_out <= cfg_ff[UMS_CFG_I2C_BIT] && (pkt_status == UMS_PKT_GOOD); // [R12]
      end
   end

   // axi write channels, taken in either order
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aw_held_ff        <= 1'b0;
         w_held_ff         <= 1'b0;
         awaddr_ff         <= 8'h00;
         wdata_ff          <= 32'h0000_0000;
         wstrb_ff          <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= 2'h0;
      end else if (clk_en_in) begin
         s_axi_awready_out <= !aw_held_ff && !s_axi_awready_out;
         s_axi_wready_out  <= !w_held_ff && !s_axi_wready_out;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_ff        <= 1'b1;
            awaddr_ff         <= {s_axi_awaddr_in[7:2], 2'h0};
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_ff        <= 1'b1;
            wdata_ff         <= s_axi_wdata_in;
            wstrb_ff         <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_ok ? 2'h0 : 2'h2; // slverr when unmapped
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_held_ff       <= 1'b0;
            w_held_ff        <= 1'b0;
         end
      end
   end

   // writable registers, byte lane 0 only
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_ff      <= UMS_CFG_RESET;
         irq_mask_ff <= '0;
         exit_cmd_ff <= 1'b0;
      end else if (clk_en_in) begin
         exit_cmd_ff <= 1'b0;
         if (wr_fire && wstrb_ff[0]) begin
            if (awaddr_ff == UMS_REG_CONFIG) begin
               cfg_ff <= wdata_ff[7:0]; // [R4]
            end
            if (awaddr_ff == UMS_REG_IRQ_MASK) begin
               irq_mask_ff <= wdata_ff[UMS_IRQ_W-1:0];
            end
            if (awaddr_ff == UMS_REG_CONTROL) begin
               exit_cmd_ff <= wdata_ff[UMS_CTL_EXIT_CMD_BIT];
            end
         end
      end
   end

   // sticky events, write one to clear; a new event wins over the clear
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_stat_ff <= '0;
         irq_out     <= 1'b0;
      end else if (clk_en_in) begin
         logic [UMS_IRQ_W-1:0] clr;
         logic [UMS_IRQ_W-1:0] set;
         clr = '0;
         set = '0;
         if (wr_fire && wstrb_ff[0] && awaddr_ff == UMS_REG_IRQ_STAT) begin
            clr = wdata_ff[UMS_IRQ_W-1:0];
         end
         set[UMS_IRQ_RESULT]  = result_wr;
         set[UMS_IRQ_SPECIAL] = special_done;
         set[UMS_IRQ_FETCH]   = result_fetch_command_in;
         irq_stat_ff <= (irq_stat_ff & ~clr) | set;
         irq_out     <= |(((irq_stat_ff & ~clr) | set) & irq_mask_ff);
      end
   end

   // axi read channel, one read at a time
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0000_0000;
         s_axi_rresp_out   <= 2'h0;
      end else if (clk_en_in) begin
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= 2'h0;
            s_axi_rdata_out   <= 32'h0000_0000;
            unique case ({s_axi_araddr_in[7:2], 2'h0})
               UMS_REG_CONFIG:   s_axi_rdata_out[7:0] <= cfg_ff;
               UMS_REG_STATUS: begin
                  s_axi_rdata_out[UMS_ST_PDOWN_BIT]  <= power_down_out;
                  s_axi_rdata_out[UMS_ST_CMD_BIT]    <= (state_ff == UMS_S_CMD);
                  s_axi_rdata_out[UMS_ST_VALID_BIT]  <= valid_ff;
                  s_axi_rdata_out[UMS_ST_STALE_BIT]  <= stale_ff;
                  s_axi_rdata_out[UMS_ST_DIAG_BIT]   <= diag_ff;
                  s_axi_rdata_out[UMS_ST_NEXTAZ_BIT] <= next_zero_ff;
                  s_axi_rdata_out[UMS_ST_GAP_LSB+7:UMS_ST_GAP_LSB] <= gap_ff;
               end
               UMS_REG_RESULT:   s_axi_rdata_out[15:0] <= {pkt_status, result_ff};
               UMS_REG_IRQ_STAT: s_axi_rdata_out[UMS_IRQ_W-1:0] <= irq_stat_ff;
               UMS_REG_IRQ_MASK: s_axi_rdata_out[UMS_IRQ_W-1:0] <= irq_mask_ff;
               UMS_REG_CONTROL:  s_axi_rdata_out <= 32'h0000_0000;
               default:          s_axi_rresp_out <= 2'h2;
            endcase
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ---- ums_props.sv ----
/* scheduler port checker.
   assumes clk_en_in held high. */
`default_nettype none
module ums_props
   import ums_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        rst_b_in,
   input wire logic        conv_start_out,
   input wire logic [1:0]  conv_kind_out,
   input wire logic        conv_done_in,
   input wire logic        calc_start_out,
   input wire logic        calc_done_in,
   input wire logic        power_down_out,
   input wire logic        result_fetch_command_in,
   input wire logic        diag_fault_in,
   input wire logic [15:0] packet_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic [1:0]  s_axi_bresp_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   input wire logic [31:0] s_axi_rdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // one-cycle start strobe; kind moves only with a start
   property p_conv_pulse; conv_start_out |=> !conv_start_out; endproperty
   a_conv_pulse: assert property (p_conv_pulse) else $error("long start");
   property p_kind; $changed(conv_kind_out) |-> conv_start_out; endproperty
   a_kind: assert property (p_kind) else $error("kind moved alone");
   // calc follows a bridge
   property p_calc;
      calc_start_out |-> $past(conv_done_in) && conv_kind_out == UMS_CONV_BRIDGE;
   endproperty
   a_calc: assert property (p_calc) else $error("calc without bridge");
   // sleep after the result
   property p_pd_rise; $rose(power_down_out) |-> $past(calc_done_in); endproperty
   a_pd_rise: assert property (p_pd_rise) else $error("early power down");
   property p_pd_conv; power_down_out |-> !conv_start_out; endproperty
   a_pd_conv: assert property (p_pd_conv) else $error("conversion asleep");
   // fetch turns good data stale
   property p_stale;
      result_fetch_command_in && packet_out[15:14] == UMS_PKT_GOOD && !diag_fault_in
         && !calc_done_in ##1 !calc_done_in |=> packet_out[15:14] == UMS_PKT_STALE;
   endproperty
   a_stale: assert property (p_stale) else $error("not stale");
   property p_bhold;
      s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
   endproperty
   a_bhold: assert property (p_bhold) else $error("b dropped");
   property p_rhold;
      s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
   endproperty
   a_rhold: assert property (p_rhold) else $error("r dropped");
endmodule
bind ums_scheduler ums_props u_props (.clock_in, .rst_b_in, .conv_start_out, .conv_kind_out,
   .conv_done_in, .calc_start_out, .calc_done_in, .power_down_out, .result_fetch_command_in,
   .diag_fault_in, .packet_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
   .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out);
`default_nettype wire

// ---- ums_afe_model.sv ----
/* converter and correction model.
   assumes one-cycle starts; answers in three cycles. */
`default_nettype none
module ums_afe_model (
   input  wire logic        clock_in,
   input  wire logic        conv_start_in,
   input  wire logic        calc_start_in,
   output logic             conv_done_out,
   output logic             calc_done_out,
   output logic [13:0]      result_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cv_ff = '0;
   logic [2:0] cl_ff = '0;
   logic [13:0] res_ff = 14'h1000;
   // delay lines; result steps so old data never looks new
   always_ff @(posedge clock_in) begin
      cv_ff <= {cv_ff[1:0], conv_start_in};
      cl_ff <= {cl_ff[1:0], calc_start_in};
      if (cl_ff[1]) res_ff <= res_ff + 14'h0001;
   end
   assign conv_done_out = cv_ff[2];
   assign calc_done_out = cl_ff[2];
   assign result_out    = res_ff;
endmodule
`default_nettype wire

// ---- ums_scheduler_test.sv ----
/* self-checking scheduler bench.
   assumes the afe model as converter. */
`default_nettype none
module ums_scheduler_test;
   import ums_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, fe = 0, df = 0;
   logic [3:0] ws = 4'hF;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdd, d;
   logic [1:0] br, rr, ck, r;
   logic awr, wrd, bv, arr, rv, cs, cc, kd, cd, rp, pd, irq, pds = 0;
   logic [13:0] res;
   logic [15:0] pkt;
   logic [1:0] kinds [3];
   int n_fail = 0, n_tests = 0, cyc = 0, lst = 0, per = 0, nk = 0, fc = 0;
   always #2.5 clk = ~clk;
   ums_scheduler #(.CYCLES_PER_US(1), .CONV_TIME_US(4)) dut (.clock_in(clk), .rst_b_in(rst),
      .clk_en_in(1'b1), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
      .mem_unlocked_in(1'b0), .enter_command_mode_request_in(1'b0), .conv_start_out(cs),
      .conv_kind_out(ck), .conv_done_in(cd), .diag_fault_in(df), .calc_start_out(cc),
      .calc_done_in(kd), .calc_result_in(res), .result_fetch_command_in(fe), .packet_out(pkt),
      .ready_pin_out(rp), .power_down_out(pd), .irq_out(irq));
   ums_afe_model afe (.clock_in(clk), .conv_start_in(cs), .calc_start_in(cc),
      .conv_done_out(cd), .calc_done_out(kd), .result_out(res));
   // start order and bridge spacing
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cs && nk == 0) fc <= cyc;
      if (cs && nk < 3) kinds[nk] <= ck;
      if (cs) nk <= nk + 1;
      if (cs && ck == 2'h0) begin per <= cyc - lst; lst <= cyc; end
      if (pd) pds <= 1;
   end
   task automatic complete_run();
      $display("checks %0d bad %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin n_fail++; $display("BAD %s exp %h got %h", n, e, s); end
   endtask
   task automatic tmo(input int i);
      if (i >= 5000) begin n_fail++; complete_run(); end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      awa <= a; wd <= v; awv <= 1; wv <= 1;
      for (i = 0; i < 5000; i++) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
         if (bre && bv) break;
         if (bv) bre <= 1;
      end
      bre <= 0; tmo(i);
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      ara <= a; arv <= 1;
      for (i = 0; i < 5000; i++) begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rre && rv) break;
         if (rv) rre <= 1;
      end
      d = rdd; r = rr; rre <= 0; tmo(i);
   endtask
   task automatic wres();
      int i;
      for (i = 0; i < 5000; i++) begin @(posedge clk); if (kd) break; end
      tmo(i); repeat (2) @(posedge clk);
   endtask
   task automatic t_boot();
      wres();
      cmp("order", {kinds[0], kinds[1], kinds[2]}, {2'h1, 2'h2, 2'h0});
      cmp("window", fc > 1500, 1);
      cmp("good", pkt[15:14], UMS_PKT_GOOD);
      cmp("rdy", rp, 1);
      wres(); wres();
      cmp("no sleep", pds, 0);
      $display("boot done");
   endtask
   task automatic t_fetch();
      fe <= 1; @(posedge clk); fe <= 0; repeat (3) @(posedge clk);
      cmp("stale", pkt[15:14], UMS_PKT_STALE);
      cmp("rdy low", rp, 0);
      wres();
      cmp("fresh", pkt[15:14], UMS_PKT_GOOD);
      $display("fetch done");
   endtask
   task automatic t_rate();
      wr(UMS_REG_CONFIG, 32'h45);
      wres(); wres(); wres();
      cmp("sleep", pd, 1);
      cmp("period", per, 1500);
      rd(UMS_REG_CONFIG);
      cmp("cfg", d, 32'h45);
      $display("rate done");
   endtask
   task automatic t_irq();
      wres(); wr(UMS_REG_IRQ_MASK, 32'h1); @(posedge clk);
      cmp("irq on", irq, 1);
      wr(UMS_REG_IRQ_STAT, 32'h7); rd(UMS_REG_IRQ_STAT);
      cmp("stat clr", d[0], 0);
      cmp("irq off", irq, 0);
      rd(8'h40);
      cmp("unmapped", r, 2'h2);
      $display("irq done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1;
      t_boot(); t_fetch(); t_rate(); t_irq();
      complete_run();
   end
endmodule
`default_nettype wire
